//--- rtl/stap_edge_if.sv
/*
 * Interface carrying the sampled test pins and the test-clock edge
 * strobes from the pin sampler to the controller.
 * Assumes one system clock for both ends.
 */
`timescale 1ns/1ps
interface stap_edge_if;
    logic tck_rise;   // One-cycle pulse on a rising test-clock edge
    logic tck_fall;   // One-cycle pulse on a falling test-clock edge
    logic tms;        // Synchronised mode select
    logic tdi;        // Synchronised serial data in

    modport src (output tck_rise, output tck_fall, output tms, output tdi);
    modport dst (input tck_rise, input tck_fall, input tms, input tdi);
endinterface

//--- rtl/stap_pin_sync.sv
/*
 * Two-flop synchronisers for the test pins and edge detection of the
 * test clock, producing strobes in the system clock domain.
 * Assumes the test clock is much slower than clk_i (64 ns vs 4 ns).
 */
`timescale 1ns/1ps
module stap_pin_sync
    import stap_pkg::*;
(
    // System
    input  wire logic  clk_i,
    input  wire logic  nrst_i,
    // Test pins
    input  wire logic  tck_i,
    input  wire logic  tms_i,
    input  wire logic  tdi_i,
    // Sampled pins and strobes
    stap_edge_if.src   edge_o
);
    logic [2:0] meta_reg;   // First stage, read by second stage only
    logic [2:0] sync_reg;
    logic       tck_last_reg;

    // Pins idle high (pull-ups) except the clock, which idles low
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            meta_reg     <= 3'h6;
            sync_reg     <= 3'h6;
            tck_last_reg <= 1'h0;
        end else begin
            meta_reg     <= {tms_i, tdi_i, tck_i};
            sync_reg     <= meta_reg;
            tck_last_reg <= sync_reg[0];
        end
    end

    // Edge strobes from the synchronised clock
    assign edge_o.tck_rise = sync_reg[0] & ~tck_last_reg;
    assign edge_o.tck_fall = ~sync_reg[0] & tck_last_reg;
    assign edge_o.tms      = sync_reg[2];
    assign edge_o.tdi      = sync_reg[1];
endmodule // stap_pin_sync

//--- rtl/stap_pkg.sv
/*
 * Package for the SRAM boundary-scan test access port: controller
 * states, instruction codes, register widths and reset values.
 * Assumes nothing of its surroundings; imported by the pin sampler and controller, not the interface.
 */
package stap_pkg;

    // Controller states of the standard boundary-scan architecture
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE,
        ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
        ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
    } stap_state_t;

    // Register widths
    localparam int          IR_W       = 3;
    localparam int          ID_W       = 32;
    localparam int          BSR_W      = 109;
    localparam int          OUT_EN_BIT = 108;

    // Instruction codes; the three codes not listed here are reserved
    localparam logic [2:0]  INS_EXTEST   = 3'h0;
    localparam logic [2:0]  INS_IDCODE   = 3'h1;
    localparam logic [2:0]  INS_SAMPLEZ  = 3'h2;
    localparam logic [2:0]  INS_PRELOAD  = 3'h4;
    localparam logic [2:0]  INS_BYPASS   = 3'h7;

    // Capture pattern of the instruction register's two low bits
    localparam logic [1:0]  IR_CAPTURE   = 2'h1;
    // Reset values
    localparam logic [2:0]  IR_RESET     = INS_IDCODE;
    localparam logic        BYP_RESET    = 1'h0;
    // Identification word; value is arbitrary, bit 0 set as the standard demands
    localparam logic [31:0] ID_WORD      = 32'h0a5c_3001;
    // Consecutive high mode-select edges that force a reset
    localparam int          RESET_EDGES  = 5;

endpackage

//--- rtl/stap_tap_ctrl.sv
/*
 * Boundary-scan test access port of a synchronous burst SRAM:
 * controller state machine, instruction, bypass, identification and
 * boundary registers, and the serial data output.
 * Assumes the test pins and the pin ring arrive asynchronously and are
 * sampled by clk_i, and that nrst_i stands for the power-up reset.
 */
// Contract
// - Follow the standard boundary-scan state machine, instructions and register behaviour.
// - Sample test inputs on rising test clock; change outputs on falling test clock.
// - Unconnected mode select and serial input read as logic high.
// - Exactly the register named by the instruction sits between input and output.
// - Serial data enters at the register's MSB and leaves from its LSB.
// - Drive serial output only in shift states; high impedance otherwise.
// - Five rising edges with mode select high return controller to reset.
// - Test port reset never affects memory reads or writes.
// - Controller resets itself at power-up so serial output starts high impedance.
// - Unused port with clock held low stays in reset, memory undisturbed.
// - No more than one scan register in the serial path at once.
// - Instruction register is three bits, loaded serially.
// - Instruction register shifts only in the instruction shift state.
// - Instruction register becomes the identification instruction at power-up and reset.
// - Instruction capture loads the two low instruction bits with 01.
// - Bypass register is one bit giving a one-stage delay.
// - Bypass instruction clears the bypass bit to zero.
// - New instruction takes effect only in the instruction update state.
// - Identification instruction captures a hardwired 32-bit word on data capture.
// - Boundary instructions capture the pin ring, then shift it serially.
`timescale 1ns/1ps
module stap_tap_ctrl
    import stap_pkg::*;
#(
    parameter int BSR_WIDTH = BSR_W
) (
    // System
    input  wire logic                  clk_i,
    input  wire logic                  nrst_i,
    // Test pins (tri-state output: enable low drives)
    input  wire logic                  tck_i,
    input  wire logic                  tms_i,
    input  wire logic                  tdi_i,
    output logic                       tdo_o,
    output logic                       tdo_oe_n_o,
    // Pin ring of the memory
    input  wire logic [BSR_WIDTH-1:0]  ring_i,
    output logic [BSR_WIDTH-1:0]       ring_o,
    output logic                       ring_drive_o,
    output logic                       qbus_hiz_o,
    // Current instruction, for observation
    output logic [IR_W-1:0]            instr_o
);
    stap_edge_if edge_bus ();

    stap_state_t            state_reg, state_next;
    logic [IR_W-1:0]        ir_shift_reg;        // scan_instruction shift stage
    logic [IR_W-1:0]        ir_reg;              // scan_instruction, current
    logic                   byp_reg;             // scan_bypass_bit
    logic [ID_W-1:0]        id_reg;
    logic [BSR_WIDTH-1:0]   bsr_reg;
    logic [BSR_WIDTH-1:0]   upd_reg;
    logic                   tdo_reg, tdo_oe_n_reg;
    logic [2:0]             tms_cnt_reg;         // Counts high mode-select edges
    logic [BSR_WIDTH-1:0]   ring_meta_reg;       // Pin ring, first sync stage
    logic [BSR_WIDTH-1:0]   ring_sync_reg;       // Pin ring, second sync stage

    // Synchronised pins; a floating pin pulls high at the pad, seen here as 1
    stap_pin_sync u_sync (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .tck_i  (tck_i),
        .tms_i  (tms_i),
        .tdi_i  (tdi_i),
        .edge_o (edge_bus)
    );

    wire rise = edge_bus.tck_rise;
    wire fall = edge_bus.tck_fall;
    wire tms  = edge_bus.tms;
    wire tdi  = edge_bus.tdi;

    // Instruction decode, used for data-path selection and pin control
    function automatic logic is_bsr(input logic [IR_W-1:0] ins);
        return ins == INS_EXTEST || ins == INS_SAMPLEZ || ins == INS_PRELOAD;
    endfunction
    function automatic logic is_id(input logic [IR_W-1:0] ins);
        return ins == INS_IDCODE;
    endfunction

    wire sel_bsr   = is_bsr(ir_reg);
    wire sel_id    = is_id(ir_reg);
    // Reserved codes fall back to bypass, keeping one register in the path
    wire sel_byp   = !sel_bsr && !sel_id;
    wire in_sh_dr  = state_reg == ST_SH_DR;
    wire in_sh_ir  = state_reg == ST_SH_IR;
    wire cnt_full  = tms_cnt_reg == 3'(RESET_EDGES - 1);
    // Serial bit presented by the single selected register, LSB first
    wire dr_lsb    = sel_bsr ? bsr_reg[0] : (sel_id ? id_reg[0] : byp_reg);
    wire serial_bit = in_sh_ir ? ir_shift_reg[0] : dr_lsb;

    // Standard controller transitions on mode select
    always_comb begin
        case (state_reg)
            ST_RESET:  state_next = tms ? ST_RESET  : ST_IDLE;
            ST_IDLE:   state_next = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: state_next = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_next = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  state_next = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: state_next = tms ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: state_next = tms ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: state_next = tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: state_next = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: state_next = tms ? ST_RESET  : ST_CAP_IR;
            ST_CAP_IR: state_next = tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  state_next = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: state_next = tms ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: state_next = tms ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: state_next = tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: state_next = tms ? ST_SEL_DR : ST_IDLE;
            default:   state_next = ST_RESET;
        endcase
    end

    // State register; the explicit counter backs up the graph's own
    // five-edge path, so a forced reset holds from any state
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            state_reg   <= ST_RESET;
            tms_cnt_reg <= 3'h0;
        end else if (rise) begin
            tms_cnt_reg <= tms ? (cnt_full ? tms_cnt_reg : tms_cnt_reg + 3'h1) : 3'h0;
            if (tms && cnt_full)
                state_reg <= ST_RESET;
            else
                state_reg <= state_next;
        end
    end

    // Instruction register: capture and shift on the rising test-clock edge;
    // the current instruction moves on the falling edge in Update or Reset,
    // so a forced reset shows at the fall after the state change, half a test clock later
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ir_shift_reg <= IR_RESET;
            ir_reg       <= IR_RESET;
        end else begin
            if (rise && state_reg == ST_CAP_IR)
                ir_shift_reg <= {ir_reg[IR_W-1], IR_CAPTURE};
            else if (rise && in_sh_ir)
                ir_shift_reg <= {tdi, ir_shift_reg[IR_W-1:1]};
            if (fall && state_reg == ST_RESET)
                ir_reg <= IR_RESET;
            else if (fall && state_reg == ST_UPD_IR)
                ir_reg <= ir_shift_reg;
        end
    end

    // Bypass bit: cleared on capture, one stage of delay in shift
    always_ff @(posedge clk_i) begin
        if (!nrst_i)
            byp_reg <= BYP_RESET;
        else if (rise && sel_byp) begin
            if (state_reg == ST_CAP_DR)
                byp_reg <= 1'h0;
            else if (in_sh_dr)
                byp_reg <= tdi;
        end
    end

    // Identification register: hardwired word captured, then shifted
    always_ff @(posedge clk_i) begin
        if (!nrst_i)
            id_reg <= ID_WORD;
        else if (rise && sel_id) begin
            if (state_reg == ST_CAP_DR)
                id_reg <= ID_WORD;
            else if (in_sh_dr)
                id_reg <= {tdi, id_reg[ID_W-1:1]};
        end
    end

    // Pin ring passes two flops; a bit moving at capture still lands clean
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ring_meta_reg <= '0;
            ring_sync_reg <= '0;
        end else begin
            ring_meta_reg <= ring_i;
            ring_sync_reg <= ring_meta_reg;
        end
    end

    // Boundary register shifts on the rising edge; the update latch moves
    // on the falling edge, so the ring never changes in mid-shift
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            bsr_reg <= '0;
            upd_reg <= BSR_WIDTH'(1) << OUT_EN_BIT;   // Output-enable cell preset high
        end else begin
            if (rise && sel_bsr && state_reg == ST_CAP_DR)
                bsr_reg <= ring_sync_reg;
            else if (rise && sel_bsr && in_sh_dr)
                bsr_reg <= {tdi, bsr_reg[BSR_WIDTH-1:1]};
            if (fall && state_reg == ST_RESET)
                upd_reg[OUT_EN_BIT] <= 1'h1;
            else if (fall && sel_bsr && state_reg == ST_UPD_DR)
                upd_reg <= bsr_reg;
        end
    end

    // Serial output retimed to the falling test-clock edge; the driver
    // turns on only in shift states, so a quiet port floats the pin
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            tdo_reg      <= 1'h0;
            tdo_oe_n_reg <= 1'h1;
        end else if (fall) begin
            tdo_reg      <= serial_bit;
            tdo_oe_n_reg <= !(in_sh_dr || in_sh_ir);
        end
    end

    // Pin-ring controls; memory operation is never touched by a test
    // reset, only EXTEST and SAMPLE Z take over the pins
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ring_o       <= '0;
            ring_drive_o <= 1'h0;
            qbus_hiz_o   <= 1'h0;
        end else begin
            ring_o       <= upd_reg;
            ring_drive_o <= ir_reg == INS_EXTEST;
            qbus_hiz_o   <= ir_reg == INS_SAMPLEZ ||
                            (ir_reg == INS_EXTEST && !upd_reg[OUT_EN_BIT]);
        end
    end

    assign tdo_o      = tdo_reg;
    assign tdo_oe_n_o = tdo_oe_n_reg;
    assign instr_o    = ir_reg;
endmodule // stap_tap_ctrl

//--- sim/stap_checker.sv
/* Assertions on the test port pins and pin-ring outputs.
   Assumes binding into stap_tap_ctrl and a test clock far slower than clk_i. */
`timescale 1ns/1ps
module stap_checker
    import stap_pkg::*;
#(parameter int BSR_WIDTH = BSR_W) (
    // System
    input wire logic                 clk_i,
    input wire logic                 nrst_i,
    // Test pins
    input wire logic                 tck_i,
    input wire logic                 tms_i,
    input wire logic                 tdo_o,
    input wire logic                 tdo_oe_n_o,
    // Ring and instruction
    input wire logic [BSR_WIDTH-1:0] ring_o,
    input wire logic                 ring_drive_o,
    input wire logic                 qbus_hiz_o,
    input wire logic [IR_W-1:0]      instr_o
);
    logic       tck_reg;
    logic       tms_reg;
    logic [2:0] hi_reg;
    wire        rise    = tck_i & ~tck_reg;
    wire  [2:0] hi_next = !tms_i ? 3'h0 : hi_reg + {2'h0, hi_reg != 3'h7};
    // One flop only, so a rise is seen before the design can react to it
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            tck_reg <= 1'h0;
            tms_reg <= 1'h1;
            hi_reg  <= 3'h0;
        end else begin
            tck_reg <= tck_i;
            if (rise) begin
                tms_reg <= tms_i;
                hi_reg  <= hi_next;
            end
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_fifth_high;
        rise && tms_i && hi_reg == 3'h4;
    endsequence
    sequence s_in_reset;
        instr_o == IR_RESET && tdo_oe_n_o;
    endsequence
    property p_rst;
        $rose(nrst_i) |-> instr_o == IR_RESET && tdo_oe_n_o && !ring_drive_o;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_five;
        s_fifth_high |-> ##[1:20] s_in_reset; // Lands after the following fall
    endproperty
    a_five: assert property (p_five) else $error("no reset after high edges");
    property p_oe_on;
        $fell(tdo_oe_n_o) |-> !tms_reg;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("output enabled outside shift");
    property p_oe_off;
        $rose(tdo_oe_n_o) |-> tms_reg;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("output released inside shift");
    property p_fall;
        $changed({tdo_o, tdo_oe_n_o}) |-> !$past(tck_i) && !$past(tck_i, 2);
    endproperty
    a_fall: assert property (p_fall) else $error("output moved off falling edge");
    property p_upd;
        $changed(instr_o) |-> tms_reg && !$past(tck_i); // Moves only after a fall
    endproperty
    a_upd: assert property (p_upd) else $error("instruction changed outside update");
    property p_drive;
        $stable(instr_o) |-> ring_drive_o == (instr_o == INS_EXTEST);
    endproperty
    a_drive: assert property (p_drive) else $error("ring drive wrong");
    property p_hiz;
        $stable(instr_o) && $stable(ring_o[OUT_EN_BIT]) |-> qbus_hiz_o ==
            (instr_o == INS_SAMPLEZ || (instr_o == INS_EXTEST && !ring_o[OUT_EN_BIT]));
    endproperty
    a_hiz: assert property (p_hiz) else $error("output bus tristate wrong");
endmodule // stap_checker

bind stap_tap_ctrl stap_checker #(.BSR_WIDTH(BSR_WIDTH)) u_chk (.clk_i(clk_i),
    .nrst_i(nrst_i), .tck_i(tck_i), .tms_i(tms_i), .tdo_o(tdo_o), .tdo_oe_n_o(tdo_oe_n_o),
    .ring_o(ring_o), .ring_drive_o(ring_drive_o), .qbus_hiz_o(qbus_hiz_o), .instr_o(instr_o));

//--- sim/stap_scan_master.sv
/* Scan master model: makes the test clock, drives mode select and data in.
   Assumes one caller at a time; the clock stands low between calls. */
`timescale 1ns/1ps
module stap_scan_master (
    // Test pins, driven
    output logic     tck_o,
    output logic     tms_o,
    output logic     tdi_o,
    // Serial data out of the device
    input wire logic tdo_i,
    input wire logic tdo_oe_n_i
);
    // Idle: clock low, released inputs read as pulled up
    initial begin
        tck_o = 1'h0;
        tms_o = 1'h1;
        tdi_o = 1'h1;
    end
    // One 64 ns period; pins change at the start, while the clock is low, 32 ns before the rise
    task automatic step(input logic tms_v, input logic tdi_v, output logic tdo_v);
        tms_o = tms_v;
        tdi_o = tdi_v;
        #32;
        tck_o = 1'h1;
        tdo_v = tdo_oe_n_i ? ~tdo_i : tdo_i; // No pull on a released line: show a wrong level
        #32;
        tck_o = 1'h0;
    endtask
    // Controller walk, pattern LSB first, data in held high
    task automatic walk(input int n, input logic [7:0] pat);
        logic x;
        for (int i = 0; i < n; i++) step(pat[i], 1'h1, x);
    endtask
    // Shift n bits LSB first, mode select high on the last
    task automatic shift(input int n, input logic [108:0] din, output logic [108:0] dout);
        dout = {109{1'h0}};
        for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
    endtask
endmodule // stap_scan_master

//--- sim/stap_tb.sv
/* Testbench: instruction and data scans through the scan master model.
   Assumes stap_checker is bound into the design. */
`timescale 1ns/1ps
module sram_jtag_test_access_port_tb_top
    import stap_pkg::*;
;
    logic             clk_i = 1'h0;
    logic             nrst_i = 1'h0;
    logic             tck_i, tms_i, tdi_i, tdo_o, tdo_oe_n_o, ring_drive_o, qbus_hiz_o;
    logic [BSR_W-1:0] ring_i = {BSR_W{1'h0}};
    logic [BSR_W-1:0] ring_o, d;
    logic [IR_W-1:0]  instr_o, cur;
    int               fail_count = 0;
    int               checks = 0;
    int               cycles = 0;
    localparam logic [BSR_W-1:0] PIN = {13'h1abc, 32'h8e3d_b1f2, 32'h1234_5678, 32'h0f0f_55aa};
    localparam logic [BSR_W-1:0] PRE = {13'h0a53, 32'h7c01_9e6d, 32'h5555_aaaa, 32'h3c3c_c3c3};
    always #2 clk_i = ~clk_i;
    stap_tap_ctrl uut (.clk_i(clk_i), .nrst_i(nrst_i), .tck_i(tck_i), .tms_i(tms_i),
        .tdi_i(tdi_i), .tdo_o(tdo_o), .tdo_oe_n_o(tdo_oe_n_o), .ring_i(ring_i),
        .ring_o(ring_o), .ring_drive_o(ring_drive_o), .qbus_hiz_o(qbus_hiz_o),
        .instr_o(instr_o));
    stap_scan_master master (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i), .tdo_i(tdo_o),
        .tdo_oe_n_i(tdo_oe_n_o));
    // Compare and count
    task automatic check(input string name, input logic [BSR_W-1:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // A hung scan must not stall the run
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 10000) begin
            fail_count++;
            end_sim();
        end
    end
    // Instruction scan from Idle back to Idle; capture shows the old high bit
    task automatic load_ir(input logic [IR_W-1:0] code);
        master.walk(4, 8'h03);
        master.shift(IR_W, {{(BSR_W-IR_W){1'h0}}, code}, d);
        check("ir capture", d[IR_W-1:0], {cur[2], IR_CAPTURE});
        check("instr held", instr_o, cur);
        master.walk(2, 8'h01);
        check("instr", instr_o, code);
        cur = code;
    endtask
    task automatic scan_dr(input int n, input logic [BSR_W-1:0] din);
        master.walk(3, 8'h01);
        master.shift(n, din, d);
        master.walk(2, 8'h01);
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        #1 nrst_i = 1'h1;
        cur = IR_RESET;
        repeat (40) @(posedge clk_i);
        #1;
        check("instr reset", instr_o, IR_RESET);
        check("oe reset", tdo_oe_n_o, 1'h1);
        master.walk(1, 8'h00);
        scan_dr(ID_W, {BSR_W{1'h0}});
        check("id word", d[ID_W-1:0], ID_WORD);
        load_ir(INS_BYPASS);
        scan_dr(4, 109'hb);
        check("bypass", d[3:0], 4'h6);
        load_ir(INS_PRELOAD);
        @(posedge clk_i);
        #1 ring_i = PIN;
        scan_dr(BSR_W, PRE);
        check("ring capture", d, PIN);
        check("ring latch", ring_o, PRE);
        load_ir(INS_EXTEST);
        check("extest", {ring_drive_o, qbus_hiz_o}, 2'h3);
        load_ir(INS_SAMPLEZ);
        check("sample z", {ring_drive_o, qbus_hiz_o}, 2'h1);
        // Five high edges from inside a data shift
        master.walk(3, 8'h01);
        repeat (5) @(posedge clk_i);
        #1;
        check("oe shift", tdo_oe_n_o, 1'h0);
        master.walk(5, 8'h1f);
        repeat (5) @(posedge clk_i);
        #1;
        cur = IR_RESET;
        check("instr tap reset", instr_o, IR_RESET);
        check("oe tap reset", tdo_oe_n_o, 1'h1);
        check("cell preset", {ring_o[OUT_EN_BIT], qbus_hiz_o}, 2'h2);
        // Power-up reset in the middle of an instruction shift
        master.walk(1, 8'h00);
        load_ir(INS_BYPASS);
        master.walk(4, 8'h03);
        repeat (5) @(posedge clk_i);
        #1;
        check("oe ir shift", tdo_oe_n_o, 1'h0);
        nrst_i = 1'h0;
        repeat (2) @(posedge clk_i);
        #1 nrst_i = 1'h1;
        check("instr power-up", instr_o, IR_RESET);
        check("oe power-up", tdo_oe_n_o, 1'h1);
        end_sim();
    end
endmodule // sram_jtag_test_access_port_tb_top
